// ==== dcsxu_pkg.sv ====
// How it works
// - a software write to checksum_value seeds the generator with the written value
// - reading checksum_value returns the running checksum and leaves it unchanged
// - checksum_type_select, control bit 15, picks IP-header mode when 1, LFSR when 0
// - in LFSR mode value bits above polynomial_length always read as zero
// - in IP-header mode the checksum lives only in the low 16 value bits
// - in IP-header mode the upper 16 value bits always read as zero
// - in IP-header mode writes and reads of the value use ones-complement form
// - in LFSR mode a set tap-enable bit xors feedback into that stage
// - in LFSR mode a clear tap-enable bit passes the previous stage straight through
// - in IP-header mode the tap-enable register has no effect
package dcsxu_pkg;

  // ==========================================================================
  // widths
  localparam int unsigned DATA_W = 32;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned POLYNOMIAL_LENGTH_W = 5;
  localparam int unsigned IP_W   = 16;

  // ==========================================================================
  // register map
  localparam logic [ADDR_W-1:0] VALUE_OFS = 8'h00;
  localparam logic [ADDR_W-1:0] TAP_OFS   = 8'h04;
  localparam logic [ADDR_W-1:0] CTRL_OFS  = 8'h08;

  // ==========================================================================
  // checksum_control fields
  localparam int unsigned CTRL_TYPE_BIT   = 15;
  localparam int unsigned CTRL_ENABLE_BIT = 7;
  localparam int unsigned CTRL_POLYNOMIAL_LENGTH_LSB   = 0;

  // ==========================================================================
  // reset values and responses
  localparam logic [DATA_W-1:0] VALUE_RESET = 32'h0000_0000;
  localparam logic [DATA_W-1:0] TAP_RESET   = 32'h0000_0000;
  localparam logic [DATA_W-1:0] CTRL_RESET  = 32'h0000_0000;
  localparam logic [1:0]        RESP_OKAY   = 2'h0;
  localparam logic [1:0]        RESP_SLVERR = 2'h2;

endpackage : dcsxu_pkg

// ==== dcsxu_step.sv ====
`timescale 1ns/10ps
module dcsxu_step
  import dcsxu_pkg::*;
#(
  parameter int unsigned WIDTH = DATA_W
) (
  input  wire logic [WIDTH-1:0]  curValue,
  input  wire logic [WIDTH-1:0]  tapEnable,
  input  wire logic [WIDTH-1:0]  lenMask,
  input  wire logic [POLYNOMIAL_LENGTH_W-1:0] polyLen,
  input  wire logic              ipMode,
  input  wire logic [WIDTH-1:0]  dataWord,
  output logic      [WIDTH-1:0]  nextValue
);

  // ==========================================================================
  // ones-complement add with end-around carry
  function automatic logic [IP_W-1:0] onesAdd(input logic [IP_W-1:0] a,
                                               input logic [IP_W-1:0] b);
    logic [IP_W:0] t;
    t = {1'b0, a} + {1'b0, b};
    return t[IP_W-1:0] + {{(IP_W-1){1'b0}}, t[IP_W]};
  endfunction : onesAdd

  logic [WIDTH-1:0] lfsr;
  logic             fb;
  logic [IP_W-1:0]  ipSum;

  // ==========================================================================
  // one word, msb first, through the lfsr; ip sum of both halves
  always_comb begin
    lfsr = curValue & lenMask;
    fb   = 1'b0;
    for (int k = WIDTH - 1; k >= 0; k--) begin
      fb   = lfsr[polyLen] ^ dataWord[k];
      lfsr = ({lfsr[WIDTH-2:0], 1'b0} ^ (tapEnable & {WIDTH{fb}})) & lenMask;
    end
    ipSum = onesAdd(onesAdd(curValue[IP_W-1:0], dataWord[WIDTH-1:IP_W]),
                    dataWord[IP_W-1:0]);
    nextValue = ipMode ? {{(WIDTH-IP_W){1'b0}}, ipSum} : lfsr;
  end

endmodule : dcsxu_step

// ==== dcsxu_top.sv ====
// Local design decisions: the AXI4-Lite register port and the register offsets.
`timescale 1ns/10ps
module dcsxu_top
  import dcsxu_pkg::*;
(
  input  wire logic              sys_clk,
  input  wire logic              rst_n,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [DATA_W-1:0] s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic      [1:0]        s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic      [DATA_W-1:0] s_axi_rdata,
  output logic      [1:0]        s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              dmaValid,
  input  wire logic [DATA_W-1:0] dmaData
);

  // ==========================================================================
  // state
  typedef struct packed {
    logic [DATA_W-1:0] value;
    logic [DATA_W-1:0] tap;
    logic              typeIp;
    logic              enable;
    logic [POLYNOMIAL_LENGTH_W-1:0] polynomial_length;
    logic              awHave;
    logic              wHave;
    logic [ADDR_W-1:0] awAddr;
    logic [DATA_W-1:0] wData;
    logic [3:0]        wStrb;
    logic              awReady;
    logic              wReady;
    logic              bValid;
    logic [1:0]        bResp;
    logic              arReady;
    logic              rValid;
    logic [DATA_W-1:0] rData;
    logic [1:0]        rResp;
  } dcsxu_state_s;

  localparam dcsxu_state_s STATE_RESET = '{
    value:   VALUE_RESET,
    tap:     TAP_RESET,
    typeIp:  CTRL_RESET[CTRL_TYPE_BIT],
    enable:  CTRL_RESET[CTRL_ENABLE_BIT],
    polynomial_length:    CTRL_RESET[CTRL_POLYNOMIAL_LENGTH_LSB +: POLYNOMIAL_LENGTH_W],
    awReady: 1'b1,
    wReady:  1'b1,
    arReady: 1'b1,
    default: '0
  };

  dcsxu_state_s state_reg;
  dcsxu_state_s state_next;

  // ==========================================================================
  // byte-lane merge of a write into an old word
  function automatic logic [DATA_W-1:0] mergeBytes(input logic [DATA_W-1:0] old,
                                                   input logic [DATA_W-1:0] wr,
                                                   input logic [3:0]        strb);
    logic [DATA_W-1:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[8*b +: 8] = wr[8*b +: 8];
      end
    end
    return r;
  endfunction : mergeBytes

  // ==========================================================================
  // views of the stored state
  logic [DATA_W-1:0] lenMask;
  logic [DATA_W-1:0] readView;
  logic [DATA_W-1:0] ctrlView;
  logic [DATA_W-1:0] seedMerged;
  logic [DATA_W-1:0] seedRaw;
  logic [DATA_W-1:0] baseValue;
  logic [DATA_W-1:0] stepValue;
  logic              doWrite;
  logic              seedWrite;
  logic              dmaTake;

  genvar gi;
  generate
    for (gi = 0; gi < DATA_W; gi++) begin : g_mask
      assign lenMask[gi] = (gi <= int'(state_reg.polynomial_length));
    end
  endgenerate

  always_comb begin
    ctrlView = '0;
    ctrlView[CTRL_TYPE_BIT]            = state_reg.typeIp;
    ctrlView[CTRL_ENABLE_BIT]          = state_reg.enable;
    ctrlView[CTRL_POLYNOMIAL_LENGTH_LSB +: POLYNOMIAL_LENGTH_W]  = state_reg.polynomial_length;
    // ip mode reads back the complement of the running sum
    if (state_reg.typeIp) begin
      readView = {{(DATA_W-IP_W){1'b0}}, ~state_reg.value[IP_W-1:0]};
    end else begin
      readView = state_reg.value & lenMask;
    end
  end

  assign doWrite    = state_reg.awHave && state_reg.wHave && !state_reg.bValid;
  assign seedWrite  = doWrite && (state_reg.awAddr == VALUE_OFS);
  assign seedMerged = mergeBytes(readView, state_reg.wData, state_reg.wStrb);
  // a seed arriving with a dma word is seeded first, then the word folds in
  assign seedRaw    = state_reg.typeIp ?
                      {{(DATA_W-IP_W){1'b0}}, ~seedMerged[IP_W-1:0]} : seedMerged;
  assign baseValue  = seedWrite ? seedRaw : state_reg.value;
  assign dmaTake    = dmaValid && state_reg.enable;

  dcsxu_step #(
    .WIDTH (DATA_W)
  ) u_step (
    .curValue  (baseValue),
    .tapEnable (state_reg.tap),
    .lenMask   (lenMask),
    .polyLen   (state_reg.polynomial_length),
    .ipMode    (state_reg.typeIp),
    .dataWord  (dmaData),
    .nextValue (stepValue)
  );

  // ==========================================================================
  // next state
  always_comb begin
    logic [DATA_W-1:0] cw;
    cw = mergeBytes(ctrlView, state_reg.wData, state_reg.wStrb);
    state_next = state_reg;
    if (s_axi_awvalid && state_reg.awReady) begin
      state_next.awHave  = 1'b1;
      state_next.awAddr  = s_axi_awaddr;
      state_next.awReady = 1'b0;
    end
    if (s_axi_wvalid && state_reg.wReady) begin
      state_next.wHave  = 1'b1;
      state_next.wData  = s_axi_wdata;
      state_next.wStrb  = s_axi_wstrb;
      state_next.wReady = 1'b0;
    end
    if (doWrite) begin
      state_next.bValid = 1'b1;
      state_next.bResp  = RESP_OKAY;
      case (state_reg.awAddr)
        VALUE_OFS: state_next.bResp = RESP_OKAY;
        TAP_OFS:   state_next.tap = mergeBytes(state_reg.tap, state_reg.wData,
                                               state_reg.wStrb);
        CTRL_OFS: begin
          state_next.typeIp = cw[CTRL_TYPE_BIT];
          state_next.enable = cw[CTRL_ENABLE_BIT];
          state_next.polynomial_length   = cw[CTRL_POLYNOMIAL_LENGTH_LSB +: POLYNOMIAL_LENGTH_W];
        end
        default:   state_next.bResp = RESP_SLVERR;
      endcase
    end
    if (state_reg.bValid && s_axi_bready) begin
      state_next.bValid  = 1'b0;
      state_next.awHave  = 1'b0;
      state_next.wHave   = 1'b0;
      state_next.awReady = 1'b1;
      state_next.wReady  = 1'b1;
    end
    state_next.value = dmaTake ? stepValue : baseValue;
    if (s_axi_arvalid && state_reg.arReady) begin
      state_next.arReady = 1'b0;
      state_next.rValid  = 1'b1;
      state_next.rResp   = RESP_OKAY;
      case (s_axi_araddr)
        VALUE_OFS: state_next.rData = readView;
        TAP_OFS:   state_next.rData = state_reg.tap;
        CTRL_OFS:  state_next.rData = ctrlView;
        default: begin
          state_next.rData = '0;
          state_next.rResp = RESP_SLVERR;
        end
      endcase
    end
    if (state_reg.rValid && s_axi_rready) begin
      state_next.rValid  = 1'b0;
      state_next.arReady = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_reg <= STATE_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  // ==========================================================================
  // outputs
  assign s_axi_awready = state_reg.awReady;
  assign s_axi_wready  = state_reg.wReady;
  assign s_axi_bvalid  = state_reg.bValid;
  assign s_axi_bresp   = state_reg.bResp;
  assign s_axi_arready = state_reg.arReady;
  assign s_axi_rvalid  = state_reg.rValid;
  assign s_axi_rdata   = state_reg.rData;
  assign s_axi_rresp   = state_reg.rResp;

  // ==========================================================================
  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  seed_load_a: assert property (
    (seedWrite && !state_reg.typeIp && state_reg.wStrb == 4'hF && !dmaTake)
      |=> state_reg.value == $past(state_reg.wData))
    else $error("seed write did not load value");

  read_keeps_a: assert property (
    (s_axi_arvalid && state_reg.arReady && !seedWrite && !dmaTake)
      |=> $stable(state_reg.value) && state_reg.rValid)
    else $error("value read disturbed checksum");

  polynomial_length_mask_a: assert property (
    (s_axi_arvalid && state_reg.arReady && s_axi_araddr == VALUE_OFS
     && !state_reg.typeIp)
      |=> (state_reg.rData & ~$past(lenMask)) == '0)
    else $error("bits above length read nonzero");

  ip_store_a: assert property (
    (dmaTake && state_reg.typeIp)
      |=> state_reg.value[DATA_W-1:IP_W] == '0)
    else $error("ip checksum spilled into upper half");

  ip_upper_a: assert property (
    (s_axi_arvalid && state_reg.arReady && s_axi_araddr == VALUE_OFS
     && state_reg.typeIp)
      |=> state_reg.rData[DATA_W-1:IP_W] == '0)
    else $error("ip mode upper half read nonzero");

  ones_comp_a: assert property (
    (seedWrite && state_reg.typeIp && state_reg.wStrb == 4'hF && !dmaTake)
      |=> state_reg.value[IP_W-1:0] == ~$past(state_reg.wData[IP_W-1:0])
          && readView[IP_W-1:0] == $past(state_reg.wData[IP_W-1:0]))
    else $error("ip seed not held in complement form");

  tap_zero_a: assert property (
    (dmaTake && !state_reg.typeIp && state_reg.tap == '0 && !seedWrite)
      |=> state_reg.value == '0)
    else $error("untapped lfsr did not shift through");

  hold_idle_a: assert property (
    (!dmaTake && !seedWrite) |=> state_reg.value == $past(state_reg.value))
    else $error("checksum moved without a data word");

  write_answer_a: assert property (
    (doWrite || (state_reg.bValid && !s_axi_bready)) |=> state_reg.bValid)
    else $error("write response dropped early");

endmodule : dcsxu_top

// ==== dcsxu_dma_model.sv ====
`timescale 1ns/10ps
// ==========================================
// dma channel: one word per cycle while asked
module dcsxu_dma_model (
  input  wire logic        sys_clk,
  input  wire logic        sendReq,
  input  wire logic [31:0] sendWord,
  output logic             dmaValid,
  output logic      [31:0] dmaData
);
  // idle data is scrambled so stale words never look valid
  initial begin
    dmaValid = 1'b0;
    dmaData  = 32'h0000_0000;
    forever begin
      @(posedge sys_clk);
      dmaValid <= sendReq;
      dmaData  <= sendReq ? sendWord : ~dmaData;
    end
  end
endmodule : dcsxu_dma_model

// ==== dma_crc_seed_xor_unit_test.sv ====
`timescale 1ns/10ps
module dma_crc_seed_xor_unit_test;
  import dcsxu_pkg::*;
  logic sys_clk, rst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic s_axi_rready, dmaValid, sendReq;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, dmaData, sendWord, d, v, t, s, w;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic [15:0] sum;
  int          n_mismatch, comparisons, p;
  dcsxu_top i_dut (
    .sys_clk       (sys_clk),
    .rst_n         (rst_n),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .dmaValid      (dmaValid),
    .dmaData       (dmaData)
  );
  dcsxu_dma_model i_dma (.sys_clk(sys_clk), .sendReq(sendReq), .sendWord(sendWord),
                         .dmaValid(dmaValid), .dmaData(dmaData));
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  // ==========================================
  // checking and reference models
  task automatic end_sim();
    if (n_mismatch == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_sim
  task automatic tick(inout int n);
    @(posedge sys_clk);
    n++;
    if (n > 100) begin
      n_mismatch++;
      $display("unexpected at %0t: bus wait ran out", $time);
      end_sim();
    end
  endtask : tick
  task automatic chk_data(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: data %h, expected %h", $time, got, exp);
    end
  endtask : chk_data
  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: resp %h, expected %h", $time, got, exp);
    end
  endtask : chk_resp
  function automatic logic [31:0] lmask(input int p);
    return 32'hFFFF_FFFF >> (31 - p);
  endfunction : lmask
  function automatic logic [31:0] lfsr(input logic [31:0] v, t, d, input int p);
    logic fb;
    for (int b = 31; b >= 0; b--) begin
      fb = v[p] ^ d[b];
      v  = ({v[30:0], 1'b0} ^ (t & {32{fb}})) & lmask(p);
    end
    return v;
  endfunction : lfsr
  function automatic logic [15:0] ipadd(input logic [15:0] a, b);
    logic [16:0] x;
    x = a + b;
    return x[15:0] + x[16];
  endfunction : ipadd
  // ==========================================
  // axi4-lite master and dma stimulus
  task automatic wr(input logic [7:0] a, input logic [31:0] dat, output logic [1:0] rs);
    int n;
    @(posedge sys_clk);
    s_axi_awaddr  <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata   <= dat;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    n = 0;
    do begin
      tick(n);
      if (s_axi_awvalid && s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] dat, output logic [1:0] rs);
    int n;
    @(posedge sys_clk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    n = 0;
    do begin
      tick(n);
      if (s_axi_arvalid && s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    dat = s_axi_rdata;
    rs  = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd
  task automatic dma_word(input logic [31:0] x);
    @(posedge sys_clk);
    sendReq  <= 1'b1;
    sendWord <= x;
  endtask : dma_word
  task automatic dma_end();
    @(posedge sys_clk);
    sendReq <= 1'b0;
    repeat (2) @(posedge sys_clk);
  endtask : dma_end
  // ==========================================
  // main sequence
  initial begin
    rst_n         = 1'b0;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid  = 1'b0;
    s_axi_bready  = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_rready  = 1'b0;
    s_axi_awaddr  = 8'h00;
    s_axi_araddr  = 8'h00;
    s_axi_wdata   = 32'h0;
    s_axi_wstrb   = 4'hF;
    sendReq       = 1'b0;
    sendWord      = 32'h0;
    n_mismatch    = 0;
    comparisons   = 0;
    void'($urandom(32'h3dce9b7f));
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    for (int a = 0; a < 12; a += 4) begin
      rd(a[7:0], d, r);
      chk_data(d, 32'h0);
      chk_resp(r, RESP_OKAY);
    end
    rd(8'h0C, d, r);
    chk_resp(r, RESP_SLVERR);
    chk_data(d, 32'h0);
    wr(8'h0C, $urandom, r);
    chk_resp(r, RESP_SLVERR);
    for (int it = 0; it < 8; it++) begin
      p = (it == 0) ? 31 : (it == 1) ? 0 : $urandom_range(31);
      t = $urandom;
      s = $urandom;
      wr(CTRL_OFS, 32'h80 | p, r);
      wr(TAP_OFS, t, r);
      wr(VALUE_OFS, s, r);
      chk_resp(r, RESP_OKAY);
      v = s & lmask(p);
      rd(VALUE_OFS, d, r);
      chk_data(d, v);
      rd(TAP_OFS, d, r);
      chk_data(d, t);
      for (int k = 0; k <= it; k++) begin
        w = $urandom;
        v = lfsr(v, t, w, p);
        dma_word(w);
      end
      dma_end();
      rd(VALUE_OFS, d, r);
      chk_data(d, v);
      rd(VALUE_OFS, d, r);
      chk_data(d, v);
      chk_resp(r, RESP_OKAY);
    end
    // byte lanes with a clear strobe keep their old bytes
    w = $urandom;
    s_axi_wstrb <= 4'h5;
    wr(TAP_OFS, w, r);
    s_axi_wstrb <= 4'hF;
    rd(TAP_OFS, d, r);
    chk_data(d, {t[31:24], w[23:16], t[15:8], w[7:0]});
    wr(CTRL_OFS, p, r);
    dma_word($urandom);
    dma_end();
    rd(VALUE_OFS, d, r);
    chk_data(d, v);
    wr(CTRL_OFS, 32'h8080, r);
    s = $urandom;
    wr(VALUE_OFS, s, r);
    sum = ~s[15:0];
    rd(VALUE_OFS, d, r);
    chk_data(d, {16'h0, s[15:0]});
    for (int k = 0; k < 6; k++) begin
      w = (k == 0) ? 32'hFFFF_FFFF : $urandom;
      sum = ipadd(ipadd(sum, w[31:16]), w[15:0]);
      dma_word(w);
    end
    dma_end();
    wr(TAP_OFS, $urandom, r);
    rd(VALUE_OFS, d, r);
    chk_data(d, {16'h0, ~sum});
    // reset in mid-run returns every register to its reset value
    rst_n <= 1'b0;
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd(VALUE_OFS, d, r);
    chk_data(d, VALUE_RESET);
    rd(TAP_OFS, d, r);
    chk_data(d, TAP_RESET);
    rd(CTRL_OFS, d, r);
    chk_data(d, CTRL_RESET);
    end_sim();
  end
endmodule : dma_crc_seed_xor_unit_test
